//--- hdl/psm_monitor.sv
// Notes on behaviour
// - Total seconds count every second except those flagged power fail.
// - Available equals total minus unavailable; items count only when available.
// - Errored second: available second with one or more pattern errors.
// - Severe second: error ratio at least 1e-3, frame or signal loss.
// - Alarm second: link down, remote fault or frame loss.
// - Ten severe/alarm seconds enter unavailability from the first one.
// - Ten non-severe seconds leave unavailability at the first one.
// - Pending seconds are counted provisionally, then recounted on decision.
// - Error-free second: available second with no error and no alarm (link down, remote fault, frame or signal loss).
`include "psm_params.svh"
`default_nettype none
module psm_monitor #(
	parameter int SEC_CYCLES = `PSM_SEC_CYCLES,
	parameter int WIN = `PSM_WIN_LEN
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic meas_start,
	input wire logic power_fail,
	input wire logic bit_pulse,
	input wire logic err_pulse,
	input wire psm_pkg::psm_alarm_t alarm_in,
	output psm_pkg::psm_counts_t counts,
	output logic unavailable,
	output logic second_done
);
	typedef enum logic [1:0] {
		PSM_AVAIL = 2'b01,
		PSM_UNAVAIL = 2'b10
	} psm_state_t;

	// Cross pin-level inputs into clk domain
	logic [1:0] s_start, s_pf, s_bit, s_err;
	logic [3:0] s_alm0, s_alm1;
	logic bit_prev_q, err_prev_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			s_start <= 2'b00;
			s_pf <= 2'b00;
			s_bit <= 2'b00;
			s_err <= 2'b00;
			s_alm0 <= 4'h0;
			s_alm1 <= 4'h0;
			bit_prev_q <= 1'b0;
			err_prev_q <= 1'b0;
		end else begin
			s_start <= {s_start[0], meas_start};
			s_pf <= {s_pf[0], power_fail};
			s_bit <= {s_bit[0], bit_pulse};
			s_err <= {s_err[0], err_pulse};
			s_alm0 <= alarm_in;
			s_alm1 <= s_alm0;
			bit_prev_q <= s_bit[1];
			err_prev_q <= s_err[1];
		end
	end
	psm_pkg::psm_alarm_t alm;
	assign alm = s_alm1;

	logic tick;
	psm_sec_tick #(.CYCLES(SEC_CYCLES)) u_tick (
		.clk(clk),
		.reset(reset | s_start[1]),
		.tick(tick)
	);

	function automatic logic [31:0] inc(input logic [31:0] v, input logic en);
		inc = v + {31'h0, en};
	endfunction

	function automatic logic [31:0] sub(input logic [31:0] v,
		input logic [4:0] n);
		sub = v - {27'h0, n};
	endfunction

	// Per-second accumulators; units count on rising edges so pulse width
	// does not matter, and the tick cycle's sample opens the new second
	logic [31:0] bits_q, bits_d, errs_q, errs_d;
	logic sloss_q, sloss_d, floss_q, floss_d, lnk_q, lnk_d, rf_q, rf_d;
	logic pf_q, pf_d, bit_rise, err_rise;
	psm_pkg::psm_class_t cls;
	always_comb begin
		bit_rise = s_bit[1] & !bit_prev_q;
		err_rise = s_err[1] & !err_prev_q;
		bits_d = inc(tick ? 32'h0 : bits_q, bit_rise);
		errs_d = inc(tick ? 32'h0 : errs_q, err_rise);
		sloss_d = (sloss_q & !tick) | alm.signal_loss;
		floss_d = (floss_q & !tick) | alm.frame_loss;
		lnk_d = (lnk_q & !tick) | alm.link_down;
		rf_d = (rf_q & !tick) | alm.remote_fault;
		pf_d = (pf_q & !tick) | s_pf[1];
		cls.errored = errs_q != 32'h0;
		cls.severe = (64'(errs_q) * `PSM_SES_DEN >= 64'(bits_q)
			&& errs_q != 32'h0) | floss_q | sloss_q;
		cls.alarmed = lnk_q | rf_q | floss_q;
		cls.clean = !(cls.errored | cls.severe | cls.alarmed);
	end
	always_ff @(posedge clk) begin
		if (reset | s_start[1]) begin
			bits_q <= 32'h0;
			errs_q <= 32'h0;
			{sloss_q, floss_q, lnk_q, rf_q, pf_q} <= 5'h0;
		end else begin
			bits_q <= bits_d;
			errs_q <= errs_d;
			{sloss_q, floss_q, lnk_q, rf_q, pf_q} <=
				{sloss_d, floss_d, lnk_d, rf_d, pf_d};
		end
	end

	// History of the pending run, newest at index 0
	psm_pkg::psm_class_t hist_q [WIN];
	psm_pkg::psm_class_t hist_d [WIN];
	psm_state_t st_q, st_d;
	logic [4:0] run_q, run_d;
	psm_pkg::psm_counts_t c_q, c_d;
	logic [4:0] n_err, n_sev, n_alm, n_clean;
	logic trig, flip;
	always_comb begin
		hist_d = hist_q;
		st_d = st_q;
		run_d = run_q;
		c_d = c_q;
		n_err = 5'h0;
		n_sev = 5'h0;
		n_alm = 5'h0;
		n_clean = 5'h0;
		trig = 1'b0;
		flip = 1'b0;
		if (tick && !pf_q) begin
			c_d.total_seconds = inc(c_q.total_seconds, 1'b1);
			for (int i = WIN - 1; i > 0; i--)
				hist_d[i] = hist_q[i - 1];
			hist_d[0] = cls;
			case (st_q)
				PSM_AVAIL: trig = cls.severe | cls.alarmed;
				PSM_UNAVAIL: trig = !cls.severe;
				default: trig = 1'b0;
			endcase
			run_d = trig ? run_q + 5'h1 : 5'h0;
			flip = trig && run_q == 5'(WIN - 1);
			// Provisional: count in current state until decided
			if (st_q == PSM_UNAVAIL) begin
				c_d.unavailable_seconds = inc(c_q.unavailable_seconds, 1'b1);
			end else begin
				c_d.errored_second = inc(c_q.errored_second, cls.errored);
				c_d.severely_errored_second =
					inc(c_q.severely_errored_second, cls.severe);
				c_d.alarm_second = inc(c_q.alarm_second, cls.alarmed);
				c_d.error_free_second = inc(c_q.error_free_second, cls.clean);
			end
			if (flip) begin
				for (int i = 0; i < WIN; i++) begin
					n_err = n_err + {4'h0, hist_d[i].errored};
					n_sev = n_sev + {4'h0, hist_d[i].severe};
					n_alm = n_alm + {4'h0, hist_d[i].alarmed};
					n_clean = n_clean + {4'h0, hist_d[i].clean};
				end
				run_d = 5'h0;
				// The run includes this second, already counted above
				if (st_q == PSM_AVAIL) begin
					st_d = PSM_UNAVAIL;
					c_d.unavailable_seconds =
						c_q.unavailable_seconds + 32'(WIN);
					c_d.errored_second = sub(c_d.errored_second, n_err);
					c_d.severely_errored_second =
						sub(c_d.severely_errored_second, n_sev);
					c_d.alarm_second = sub(c_d.alarm_second, n_alm);
					c_d.error_free_second =
						sub(c_d.error_free_second, n_clean);
				end else begin
					st_d = PSM_AVAIL;
					c_d.unavailable_seconds = sub(c_d.unavailable_seconds,
						5'(WIN));
					c_d.errored_second = c_q.errored_second + 32'(n_err);
					c_d.severely_errored_second =
						c_q.severely_errored_second + 32'(n_sev);
					c_d.alarm_second = c_q.alarm_second + 32'(n_alm);
					c_d.error_free_second =
						c_q.error_free_second + 32'(n_clean);
				end
			end
		end
		c_d.available_seconds =
			c_d.total_seconds - c_d.unavailable_seconds;
	end
	always_ff @(posedge clk) begin
		if (reset | s_start[1]) begin
			st_q <= PSM_AVAIL;
			run_q <= 5'h0;
			c_q <= '0;
			second_done <= 1'b0;
			for (int i = 0; i < WIN; i++)
				hist_q[i] <= '0;
		end else begin
			st_q <= st_d;
			run_q <= run_d;
			c_q <= c_d;
			second_done <= tick;
			hist_q <= hist_d;
		end
	end
	assign counts = c_q;
	// Bit 1 of the one-hot state is the unavailable flop itself
	assign unavailable = st_q[1];

	property p_avail;
		@(posedge clk) disable iff (reset)
		c_q.available_seconds == c_q.total_seconds - c_q.unavailable_seconds;
	endproperty
	a_avail: assert property (p_avail) else $error("avail mismatch");

	property p_total;
		@(posedge clk) disable iff (reset | s_start[1])
		(tick && !pf_q) |=>
		c_q.total_seconds == $past(c_q.total_seconds) + 32'h1;
	endproperty
	a_total: assert property (p_total) else $error("total not counted");

	property p_pf;
		@(posedge clk) disable iff (reset | s_start[1])
		(tick && pf_q) |=> $stable(c_q.total_seconds);
	endproperty
	a_pf: assert property (p_pf) else $error("power fail counted");

	property p_enter;
		@(posedge clk) disable iff (reset | s_start[1])
		(flip && st_q == PSM_AVAIL) |=> unavailable;
	endproperty
	a_enter: assert property (p_enter) else $error("no enter");

	property p_exit;
		@(posedge clk) disable iff (reset | s_start[1])
		(flip && st_q == PSM_UNAVAIL) |=> !unavailable;
	endproperty
	a_exit: assert property (p_exit) else $error("no exit");

	property p_unav_step;
		@(posedge clk) disable iff (reset | s_start[1])
		(tick && !pf_q && !flip && st_q == PSM_UNAVAIL) |=>
		c_q.unavailable_seconds == $past(c_q.unavailable_seconds) + 32'h1;
	endproperty
	a_unav_step: assert property (p_unav_step) else $error("unav step");

	property p_err_hold;
		@(posedge clk) disable iff (reset | s_start[1])
		!tick |=> $stable(c_q.errored_second);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("errored moved");

	property p_clean;
		@(posedge clk) disable iff (reset | s_start[1])
		(tick && !pf_q && !flip && st_q == PSM_AVAIL && cls.clean) |=>
		c_q.error_free_second == $past(c_q.error_free_second) + 32'h1;
	endproperty
	a_clean: assert property (p_clean) else $error("clean lost");

	property p_clear;
		@(posedge clk) disable iff (reset)
		s_start[1] |=> c_q.total_seconds == 32'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("no clear");
endmodule
`default_nettype wire

//--- hdl/psm_params.svh
`ifndef PSM_PARAMS_SVH
`define PSM_PARAMS_SVH
`define PSM_CLK_HZ 100000000
`define PSM_SEC_CYCLES (`PSM_CLK_HZ)
`define PSM_WIN_LEN 10
`define PSM_SES_DEN 1000
`define PSM_CNT_W 32
`define PSM_BIT_W 32
`endif

//--- hdl/psm_pkg.sv
`default_nettype none
package psm_pkg;
	typedef struct packed {
		logic frame_loss;
		logic signal_loss;
		logic link_down;
		logic remote_fault;
	} psm_alarm_t;
	typedef struct packed {
		logic severe;
		logic errored;
		logic alarmed;
		logic clean;
	} psm_class_t;
	typedef struct packed {
		logic [31:0] total_seconds;
		logic [31:0] unavailable_seconds;
		logic [31:0] available_seconds;
		logic [31:0] errored_second;
		logic [31:0] severely_errored_second;
		logic [31:0] alarm_second;
		logic [31:0] error_free_second;
	} psm_counts_t;
endpackage
`default_nettype wire

//--- hdl/psm_sec_tick.sv
`include "psm_params.svh"
`default_nettype none
module psm_sec_tick #(
	parameter int CYCLES = `PSM_SEC_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	output logic tick
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic tick_d;
	always_comb begin
		tick_d = (cnt_q == 32'(CYCLES - 1));
		cnt_d = tick_d ? 32'h0 : cnt_q + 32'h1;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= 32'h0;
			tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick <= tick_d;
		end
	end
endmodule
`default_nettype wire

//--- dv/psm_rx_model.sv
`default_nettype none
module psm_rx_model (
	input wire logic clk,
	output logic bit_pulse,
	output logic err_pulse,
	output psm_pkg::psm_alarm_t alarm_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		bit_pulse = 1'b0;
		err_pulse = 1'b0;
		alarm_in = '0;
	end
	// Each unit is high one cycle and low one cycle, so every unit is a
	// rising edge of its own behind the receive sync flops
	task automatic run(input int bits, input int errs,
		input psm_pkg::psm_alarm_t al);
		alarm_in = al;
		for (int i = 0; i < bits; i++) begin
			@(posedge clk);
			#1;
			bit_pulse = 1'b1;
			err_pulse = (i < errs);
			@(posedge clk);
			#1;
			bit_pulse = 1'b0;
			err_pulse = 1'b0;
		end
		// Alarm levels stand a while and clear well before the second ends
		repeat (16) @(posedge clk);
		#1;
		alarm_in = '0;
	endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Long enough for a burst of a thousand and one units in one second
	localparam int SEC = 2200;
	localparam logic [3:0] ALARMS [3] = '{4'h8, 4'h2, 4'h1};
	logic clk, reset, meas_start, power_fail;
	logic bit_pulse, err_pulse, unavailable, second_done;
	psm_pkg::psm_alarm_t alarm_in;
	psm_pkg::psm_counts_t cnt, ex;
	int miscompares = 0;
	int samples_checked = 0;
	psm_monitor #(.SEC_CYCLES(SEC), .WIN(10)) i_psm_monitor (
		.clk(clk), .reset(reset), .meas_start(meas_start),
		.power_fail(power_fail), .bit_pulse(bit_pulse),
		.err_pulse(err_pulse), .alarm_in(alarm_in), .counts(cnt),
		.unavailable(unavailable), .second_done(second_done));
	psm_rx_model i_psm_rx_model (.clk(clk), .bit_pulse(bit_pulse),
		.err_pulse(err_pulse), .alarm_in(alarm_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wait_sec();
		for (int n = 0; n <= 2 * SEC; n++) begin
			@(posedge clk);
			#1;
			if (second_done === 1'b1)
				return;
		end
		check("second_done", 32'h0, 32'h1);
		conclude();
	endtask
	task automatic cmp_all(input logic u);
		check("total", cnt.total_seconds, ex.total_seconds);
		check("unavailable", cnt.unavailable_seconds,
			ex.unavailable_seconds);
		check("available", cnt.available_seconds,
			ex.available_seconds);
		check("errored", cnt.errored_second, ex.errored_second);
		check("severe", cnt.severely_errored_second,
			ex.severely_errored_second);
		check("alarm", cnt.alarm_second, ex.alarm_second);
		check("error_free", cnt.error_free_second,
			ex.error_free_second);
		check("state", {31'h0, unavailable}, {31'h0, u});
	endtask
	task automatic one_sec(input int b, input int e, input logic [3:0] al,
		input logic pf);
		power_fail = pf;
		i_psm_rx_model.run(b, e, al);
		power_fail = 1'b0;
		wait_sec();
	endtask
	task automatic bump(input int err_n, input int sev_n, input int alm_n,
		input int clean_n);
		ex.total_seconds += 32'h1;
		ex.available_seconds += 32'h1;
		ex.errored_second += 32'(err_n);
		ex.severely_errored_second += 32'(sev_n);
		ex.alarm_second += 32'(alm_n);
		ex.error_free_second += 32'(clean_n);
	endtask
	task automatic sc_items();
		one_sec(10, 1, 4'h0, 1'b0);
		bump(1, 1, 0, 0);
		cmp_all(1'b0);
		foreach (ALARMS[k]) begin
			one_sec(0, 0, ALARMS[k], 1'b0);
			bump(0, int'(ALARMS[k][3]), 1, 0);
			cmp_all(1'b0);
		end
		// One in a thousand is severe, one in a thousand and one is not
		one_sec(1000, 1, 4'h0, 1'b0);
		bump(1, 1, 0, 0);
		cmp_all(1'b0);
		one_sec(1001, 1, 4'h0, 1'b0);
		bump(1, 0, 0, 0);
		cmp_all(1'b0);
		one_sec(10, 0, 4'h0, 1'b0);
		bump(0, 0, 0, 1);
		cmp_all(1'b0);
		one_sec(5, 1, 4'h4, 1'b1);
		cmp_all(1'b0);
	endtask
	task automatic sc_enter();
		for (int i = 1; i <= 10; i++) begin
			one_sec(0, 0, 4'h4, 1'b0);
			bump(0, 1, 0, 0);
			if (i == 10) begin
				ex.severely_errored_second -= 32'hA;
				ex.available_seconds -= 32'hA;
				ex.unavailable_seconds += 32'hA;
			end
			cmp_all(i == 10);
		end
	endtask
	task automatic sc_exit();
		for (int i = 1; i <= 10; i++) begin
			one_sec(0, 0, 4'h0, 1'b0);
			ex.total_seconds += 32'h1;
			ex.unavailable_seconds += 32'h1;
			if (i == 10) begin
				ex.unavailable_seconds -= 32'hA;
				ex.available_seconds += 32'hA;
				ex.error_free_second += 32'hA;
			end
			cmp_all(i != 10);
		end
	endtask
	task automatic sc_restart();
		meas_start = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		meas_start = 1'b0;
		ex = '0;
		repeat (4) @(posedge clk);
		#1;
		cmp_all(1'b0);
		wait_sec();
		bump(0, 0, 0, 1);
		cmp_all(1'b0);
	endtask
	initial begin
		reset = 1'b1;
		meas_start = 1'b0;
		power_fail = 1'b0;
		ex = '0;
		repeat (12) @(posedge clk);
		#1;
		reset = 1'b0;
		wait_sec();
		bump(0, 0, 0, 1);
		cmp_all(1'b0);
		sc_items();
		sc_enter();
		sc_exit();
		sc_restart();
		conclude();
	end
endmodule
`default_nettype wire
